//--- hw/tlm_consts.vh
// Constants for the temperature limit monitor control block
`ifndef TLM_CONSTS_VH
`define TLM_CONSTS_VH
// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define TLM_A_CFG 8'h00
`define TLM_A_LIM1 8'h04
`define TLM_A_LIM2 8'h08
`define TLM_A_HYST 8'h0C
`define TLM_A_OFFS 8'h10
`define TLM_A_COLD 8'h14
`define TLM_A_DLY 8'h18
`define TLM_A_PIN 8'h1C
`define TLM_A_CMD 8'h20
`define TLM_A_STAT 8'h24
`define TLM_A_ERR 8'h28
// ----------------------------------------
// Fields and encodings
// ----------------------------------------
`define TLM_MODE_STD 2'h0
`define TLM_MODE_WATCH 2'h1
`define TLM_MODE_LIMITER 2'h2
`define TLM_MODE_HAZ 2'h3
`define TLM_DIR_OVER 2'h0
`define TLM_DIR_UNDER 2'h1
`define TLM_DIR_WIN 2'h2
`define TLM_TYPE_RES_MAX 4'h4
`define TLM_TYPE_TC_MAX 4'hC
`define TLM_CFG_RST 32'h00000201
`define TLM_OFF_TMAX 8'h63
`define TLM_OFF_LMAX 8'h0A
`define TLM_COLD_MIN 8'hE7
`define TLM_COLD_MAX 8'h50
`define TLM_PIN_RST 10'h000
`define TLM_ERR_STUCK 16'hB703
// ----------------------------------------
// Timing
// ----------------------------------------
`define TLM_CLK_HZ 20000000
`define TLM_TICK_MS 1
`define TLM_TICK_CYC (`TLM_CLK_HZ / 1000 * `TLM_TICK_MS)
`define TLM_TENTH_MS 100
`define TLM_REARM_MIN_MS 300
`define TLM_REARM_MAX_MS 2000
`define TLM_STUCK_MIN 5
`define TLM_STUCK_MS (`TLM_STUCK_MIN * 60 * 1000)
`define TLM_HOLD_MS 2000
`endif

//--- hw/tlm_rearm_timer.v
// Closure timer for the remote rearm terminals
`timescale 1ns/1ps
`default_nettype none
`include "tlm_consts.vh"
module tlm_rearm_timer #(
  parameter MIN_MS = `TLM_REARM_MIN_MS,
  parameter MAX_MS = `TLM_REARM_MAX_MS,
  parameter STUCK_MS = `TLM_STUCK_MS
) (
  input wire clk,
  input wire rst_n,
  input wire msTick,
  input wire closed,
  output reg rearmPulse,
  output reg stuck
);
  reg [18:0] cnt_r;
  reg closedPrev_r;
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_r <= 19'h00000;
      closedPrev_r <= 1'b0;
      rearmPulse <= 1'b0;
      stuck <= 1'b0;
    end
    else
    begin
      closedPrev_r <= closed;
      if (!closed)
        cnt_r <= 19'h00000;
      else if (msTick && cnt_r < STUCK_MS[18:0])
        cnt_r <= cnt_r + 19'h00001;
      // Judged on the opening edge, so a too-long closure never fires
      rearmPulse <= closedPrev_r && !closed && cnt_r >= MIN_MS[18:0]
        && cnt_r <= MAX_MS[18:0] && !stuck;
      // Latched until supply loss; only rst_n clears it
      if (cnt_r >= STUCK_MS[18:0])
        stuck <= 1'b1;
    end
  end
endmodule
`default_nettype wire

//--- hw/tlm_trip_delay.v
// Trip delay counter in tenth-second steps
`timescale 1ns/1ps
`default_nettype none
module tlm_trip_delay #(
  parameter DLY_W = 14
) (
  input wire clk,
  input wire rst_n,
  input wire tenthTick,
  input wire viol,
  input wire [DLY_W-1:0] delay,
  output reg fire
);
  reg [DLY_W-1:0] cnt_r;
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_r <= {DLY_W{1'b0}};
      fire <= 1'b0;
    end
    else
    begin
      if (!viol)
        cnt_r <= {DLY_W{1'b0}};
      else if (tenthTick && cnt_r != delay)
        cnt_r <= cnt_r + {{(DLY_W-1){1'b0}}, 1'b1};
      // Zero delay means off: the violation passes straight through
      fire <= viol && (delay == {DLY_W{1'b0}} || cnt_r == delay);
    end
  end
endmodule
`default_nettype wire

//--- hw/tlm_ctrl.v
// Control core of the temperature limit monitor with APB registers
`timescale 1ns/1ps
`default_nettype none
`include "tlm_consts.vh"
module tlm_ctrl #(
  parameter TICK_CYC = `TLM_TICK_CYC,
  parameter STUCK_MS = `TLM_STUCK_MS
) (
  input wire clk,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output reg pslverr,
  input wire signed [15:0] sensorInputOne,
  input wire signed [15:0] sensorInputTwo,
  input wire signed [15:0] sensorInputThree,
  input wire signed [15:0] loopMeas,
  input wire [2:0] shortFault,
  input wire [2:0] breakFault,
  input wire [3:0] rangeFault,
  input wire expLinkOk,
  input wire paramErr,
  input wire remoteRearmClosed,
  input wire fieldbusResetCmd,
  input wire enterButton,
  input wire savedTrip,
  output reg tripToSave,
  output reg outputRelayOne,
  output reg outputRelayTwo,
  output reg indRed,
  output reg [3:0] faultIcons,
  output reg safeState,
  output reg setMode,
  output reg signed [7:0] coldRef,
  output reg coldExt
);
  // ----------------------------------------
  // Configuration state
  // ----------------------------------------
  reg [2:0] sen_r;
  reg loopEn_r, expEn_r, memory_r, autoRst_r, openPrinc_r, extCold_r;
  reg [1:0] devMode_r, dir_r;
  reg [3:0] sType_r;
  reg signed [15:0] lim1_r, lim2_r, hyst_r;
  reg signed [7:0] off1_r, off2_r, off3_r, offL_r, cold_r;
  reg [13:0] delay_r;
  reg [9:0] pin_r;
  reg pinUse_r, pinStage_r, unlocked_r;
  reg trip1_r, trip2_r, bootDone_r;
  reg [14:0] tickCnt_r;
  reg [6:0] tenthCnt_r;
  reg [10:0] holdCnt_r;
  reg msTick, tenthTick;
  wire rearmPulse, stuck, fire1, fire2;

  function signed [7:0] clampF;
    input signed [7:0] v;
    input signed [7:0] lo;
    input signed [7:0] hi;
    begin
      clampF = (v < lo) ? lo : (v > hi) ? hi : v;
    end
  endfunction

  function violF;
    input signed [15:0] v;
    input signed [15:0] l1;
    input signed [15:0] l2;
    input [1:0] d;
    begin
      case (d)
        `TLM_DIR_OVER: violF = v > l1;
        `TLM_DIR_UNDER: violF = v < l1;
        default: violF = (v > l1) || (v < l2);
      endcase
    end
  endfunction

  function okF;
    input signed [15:0] v;
    input signed [15:0] l1;
    input signed [15:0] l2;
    input signed [15:0] h;
    input [1:0] d;
    begin
      case (d)
        `TLM_DIR_OVER: okF = v <= l1 - h;
        `TLM_DIR_UNDER: okF = v >= l1 + h;
        default: okF = (v <= l1 - h) && (v >= l2 + h);
      endcase
    end
  endfunction

  function signed [15:0] ext8;
    input signed [7:0] v;
    begin
      ext8 = {{8{v[7]}}, v};
    end
  endfunction

  // ----------------------------------------
  // Measurement and limit checks
  // ----------------------------------------
  wire signed [15:0] c1 = sensorInputOne + ext8(off1_r);
  wire signed [15:0] c2 = sensorInputTwo + ext8(off2_r);
  wire signed [15:0] c3 = sensorInputThree + ext8(off3_r);
  wire signed [15:0] cL = loopMeas + ext8(offL_r);
  wire [3:0] act = {loopEn_r, sen_r};
  wire isRes = sType_r <= `TLM_TYPE_RES_MAX;
  wire stdMode = devMode_r == `TLM_MODE_STD;
  reg viol1, viol2, allOk;
  always @*
  begin
    viol1 = (act[0] && violF(c1, lim1_r, lim2_r, dir_r))
      || (act[1] && violF(c2, lim1_r, lim2_r, dir_r))
      || (act[2] && violF(c3, lim1_r, lim2_r, dir_r))
      || (act[3] && violF(cL, lim1_r, lim2_r, dir_r));
    viol2 = dir_r != `TLM_DIR_WIN && (
      (act[0] && violF(c1, lim2_r, lim2_r, dir_r))
      || (act[1] && violF(c2, lim2_r, lim2_r, dir_r))
      || (act[2] && violF(c3, lim2_r, lim2_r, dir_r))
      || (act[3] && violF(cL, lim2_r, lim2_r, dir_r)));
    allOk = (!act[0] || okF(c1, lim1_r, lim2_r, hyst_r, dir_r))
      && (!act[1] || okF(c2, lim1_r, lim2_r, hyst_r, dir_r))
      && (!act[2] || okF(c3, lim1_r, lim2_r, hyst_r, dir_r))
      && (!act[3] || okF(cL, lim1_r, lim2_r, hyst_r, dir_r));
  end

  wire [2:0] brk = breakFault & sen_r;
  wire anyBreak = |brk;
  wire [3:0] icons = {expEn_r && !expLinkOk, |(rangeFault & act),
    anyBreak, isRes && |(shortFault & sen_r)};
  // Limit monitoring stops in the safe state; fault icons still update
  wire monOn = !safeState;
  // Delay is only honoured in standard mode
  wire [13:0] delayEff = stdMode ? delay_r : 14'h0000;

  // ----------------------------------------
  // Time base
  // ----------------------------------------
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tickCnt_r <= 15'h0000;
      tenthCnt_r <= 7'h00;
      msTick <= 1'b0;
      tenthTick <= 1'b0;
    end
    else
    begin
      msTick <= tickCnt_r == TICK_CYC[14:0] - 15'h0001;
      tickCnt_r <= (tickCnt_r == TICK_CYC[14:0] - 15'h0001) ? 15'h0000
        : tickCnt_r + 15'h0001;
      tenthTick <= msTick && tenthCnt_r == `TLM_TENTH_MS - 1;
      if (msTick)
        tenthCnt_r <= (tenthCnt_r == `TLM_TENTH_MS - 1) ? 7'h00 : tenthCnt_r + 7'h01;
    end
  end

  tlm_rearm_timer #(
    .MIN_MS(`TLM_REARM_MIN_MS),
    .MAX_MS(`TLM_REARM_MAX_MS),
    .STUCK_MS(STUCK_MS)
  ) uRearm (
    .clk(clk),
    .rst_n(rst_n),
    .msTick(msTick),
    .closed(remoteRearmClosed),
    .rearmPulse(rearmPulse),
    .stuck(stuck)
  );

  tlm_trip_delay #(.DLY_W(14)) uDly1 (
    .clk(clk),
    .rst_n(rst_n),
    .tenthTick(tenthTick),
    .viol(viol1 && monOn),
    .delay(delayEff),
    .fire(fire1)
  );

  tlm_trip_delay #(.DLY_W(14)) uDly2 (
    .clk(clk),
    .rst_n(rst_n),
    .tenthTick(tenthTick),
    .viol(viol2 && monOn),
    .delay(delayEff),
    .fire(fire2)
  );

  // ----------------------------------------
  // APB access
  // ----------------------------------------
  assign pready = 1'b1;
  wire setup = psel && !penable;
  wire wrAcc = psel && penable && pwrite;
  wire wrOk = !pinUse_r || unlocked_r;
  wire mapped = paddr <= `TLM_A_ERR && paddr[1:0] == 2'b00;
  wire wCfg = wrAcc && paddr == `TLM_A_CFG && wrOk;
  wire wCmd = wrAcc && paddr == `TLM_A_CMD;
  wire facDo = wCmd && pwdata[0] && pwdata[1] && wrOk;
  wire learnDo = wCmd && pwdata[2] && wrOk && !safeState;
  wire exitSet = wCmd && pwdata[5];
  wire [9:0] code = pwdata[9:0];
  // Every reset source funnels into one request
  wire rstReq = (wCmd && pwdata[3]) || (wCmd && pwdata[4]) || fieldbusResetCmd
    || rearmPulse || (autoRst_r && !memory_r);
  wire rstAcc = rstReq && allOk && monOn;

  // Learn reference and its percentages
  wire signed [15:0] refMeas = sen_r[0] ? c1 : sen_r[1] ? c2 : c3;
  wire [15:0] refAbs = refMeas[15] ? -refMeas : refMeas;
  wire signed [15:0] p5 = refAbs / 16'd20;
  wire signed [15:0] p10 = refAbs / 16'd10;

  // Fields of a configuration write after interlocks
  reg [2:0] nSen;
  reg nLoop;
  reg [3:0] nType;
  reg [1:0] nDir;
  always @*
  begin
    nSen = pwdata[2:0];
    nLoop = pwdata[3];
    if (pwdata[6:5] == `TLM_MODE_HAZ)
    begin
      nSen = 3'b000;
      nLoop = 1'b1;
    end
    else if (nLoop)
      nSen = 3'b000;
    else if (nSen == 3'b000)
      nSen = sen_r;
    nType = (pwdata[4] && pwdata[15:12] > `TLM_TYPE_RES_MAX) ? sType_r
      : pwdata[15:12];
    nDir = (pwdata[8:7] == 2'b11 || (pwdata[8:7] == `TLM_DIR_WIN
      && pwdata[6:5] != `TLM_MODE_STD)) ? dir_r : pwdata[8:7];
  end

  task loadDefaults;
    begin
      sen_r <= 3'b001;
      loopEn_r <= 1'b0;
      expEn_r <= 1'b0;
      devMode_r <= `TLM_MODE_STD;
      dir_r <= `TLM_DIR_OVER;
      memory_r <= 1'b1;
      autoRst_r <= 1'b0;
      openPrinc_r <= 1'b0;
      sType_r <= 4'h0;
      extCold_r <= 1'b0;
      lim1_r <= 16'sh0000;
      lim2_r <= 16'sh0000;
      hyst_r <= 16'sh0001;
      off1_r <= 8'sh00;
      off2_r <= 8'sh00;
      off3_r <= 8'sh00;
      offL_r <= 8'sh00;
      cold_r <= 8'sh00;
      delay_r <= 14'h0000;
      pin_r <= `TLM_PIN_RST;
      pinUse_r <= 1'b0;
      pinStage_r <= 1'b0;
      unlocked_r <= 1'b0;
    end
  endtask

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      loadDefaults;
    else if (facDo)
      loadDefaults;
    else if (wrAcc)
    begin
      if (wCfg)
      begin
        sen_r <= nSen;
        loopEn_r <= nLoop;
        expEn_r <= pwdata[4];
        devMode_r <= pwdata[6:5];
        dir_r <= nDir;
        memory_r <= pwdata[9];
        autoRst_r <= pwdata[10] && !pwdata[9];
        openPrinc_r <= pwdata[11];
        sType_r <= nType;
        extCold_r <= pwdata[16];
      end
      if (paddr == `TLM_A_LIM1 && wrOk)
        lim1_r <= pwdata[15:0];
      if (paddr == `TLM_A_LIM2 && wrOk)
        lim2_r <= pwdata[15:0];
      if (paddr == `TLM_A_HYST && wrOk)
        hyst_r <= pwdata[15:0];
      if (paddr == `TLM_A_OFFS && wrOk)
      begin
        off1_r <= clampF(pwdata[7:0], -`TLM_OFF_TMAX, `TLM_OFF_TMAX);
        off2_r <= clampF(pwdata[15:8], -`TLM_OFF_TMAX, `TLM_OFF_TMAX);
        off3_r <= clampF(pwdata[23:16], -`TLM_OFF_TMAX, `TLM_OFF_TMAX);
        offL_r <= clampF(pwdata[31:24], -`TLM_OFF_LMAX, `TLM_OFF_LMAX);
      end
      if (paddr == `TLM_A_COLD && wrOk)
        cold_r <= clampF(pwdata[7:0], `TLM_COLD_MIN, `TLM_COLD_MAX);
      if (paddr == `TLM_A_DLY && wrOk)
        delay_r <= pwdata[13:0];
      if (paddr == `TLM_A_PIN)
      begin
        if (pwdata[17])
        begin
          // Old code first, new code on the next key write
          if (pinStage_r)
            pin_r <= code;
          pinStage_r <= !pinStage_r && code == pin_r;
        end
        if (pwdata[18])
          unlocked_r <= code == pin_r;
        if (wrOk)
          pinUse_r <= pwdata[16];
      end
      if (learnDo)
      begin
        // Overshoot raises both limits, undershoot lowers them
        case (dir_r)
          `TLM_DIR_OVER:
          begin
            lim2_r <= refMeas + p5;
            lim1_r <= refMeas + p10;
          end
          `TLM_DIR_UNDER:
          begin
            lim2_r <= refMeas - p5;
            lim1_r <= refMeas - p10;
          end
          default:
          begin
            lim1_r <= refMeas + p10;
            lim2_r <= refMeas - p10;
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // Trip state, safe state and set mode
  // ----------------------------------------
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      trip1_r <= 1'b0;
      trip2_r <= 1'b0;
      bootDone_r <= 1'b0;
      safeState <= 1'b0;
      setMode <= 1'b0;
      holdCnt_r <= 11'h000;
    end
    else
    begin
      bootDone_r <= 1'b1;
      if (!bootDone_r)
        trip1_r <= memory_r && savedTrip;
      else if (fire1)
        trip1_r <= 1'b1;
      else if (rstAcc || safeState)
        trip1_r <= 1'b0;
      if (fire2)
        trip2_r <= 1'b1;
      else if (rstAcc || safeState)
        trip2_r <= 1'b0;
      if (enterButton && msTick && holdCnt_r <= `TLM_HOLD_MS)
        holdCnt_r <= holdCnt_r + 11'h001;
      else if (!enterButton)
        holdCnt_r <= 11'h000;
      if (facDo || paramErr)
        safeState <= 1'b1;
      else if (holdCnt_r > `TLM_HOLD_MS)
        safeState <= 1'b0;
      if (holdCnt_r > `TLM_HOLD_MS)
        setMode <= 1'b1;
      else if (exitSet)
        setMode <= 1'b0;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Only standard mode may run open-circuit; others stay closed-circuit
  wire openEff = openPrinc_r && stdMode;
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      outputRelayOne <= 1'b0;
      outputRelayTwo <= 1'b0;
      indRed <= 1'b0;
      faultIcons <= 4'h0;
      tripToSave <= 1'b0;
      coldRef <= 8'sh00;
      coldExt <= 1'b0;
    end
    else
    begin
      if (anyBreak || safeState)
      begin
        outputRelayOne <= 1'b0;
        outputRelayTwo <= 1'b0;
      end
      else
      begin
        outputRelayOne <= openEff ? trip1_r : !trip1_r;
        outputRelayTwo <= openEff ? trip2_r : !trip2_r;
      end
      indRed <= trip1_r || trip2_r || |icons || stuck;
      faultIcons <= icons;
      tripToSave <= trip1_r;
      coldRef <= cold_r;
      coldExt <= extCold_r && !isRes && sType_r <= `TLM_TYPE_TC_MAX;
    end
  end

  // Read data is captured in the setup cycle and stands through access
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else if (setup)
    begin
      pslverr <= !mapped;
      case (paddr)
        `TLM_A_CFG: prdata <= {15'h0000, extCold_r, sType_r, openPrinc_r,
          autoRst_r, memory_r, dir_r, devMode_r, expEn_r, loopEn_r, sen_r};
        `TLM_A_LIM1: prdata <= {{16{lim1_r[15]}}, lim1_r};
        `TLM_A_LIM2: prdata <= {{16{lim2_r[15]}}, lim2_r};
        `TLM_A_HYST: prdata <= {{16{hyst_r[15]}}, hyst_r};
        `TLM_A_OFFS: prdata <= {offL_r, off3_r, off2_r, off1_r};
        `TLM_A_COLD: prdata <= {{24{cold_r[7]}}, cold_r};
        `TLM_A_DLY: prdata <= {18'h00000, delay_r};
        `TLM_A_PIN: prdata <= {12'h000, unlocked_r, 1'b0, pinStage_r,
          pinUse_r, 16'h0000};
        `TLM_A_STAT: prdata <= {20'h00000, stuck, setMode, safeState, trip2_r,
          trip1_r, outputRelayTwo, outputRelayOne, indRed, faultIcons};
        `TLM_A_ERR: prdata <= {16'h0000, stuck ? `TLM_ERR_STUCK : 16'h0000};
        default: prdata <= 32'h00000000;
      endcase
    end
  end
endmodule
`default_nettype wire

//--- test/tlm_ctrl_chk.sv
// Port-level assertion checker for the limit monitor control core
`timescale 1ns/1ps
`default_nettype none
module tlm_ctrl_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic [2:0] shortFault,
  input wire logic [2:0] breakFault,
  input wire logic [3:0] rangeFault,
  input wire logic outputRelayOne,
  input wire logic outputRelayTwo,
  input wire logic indRed,
  input wire logic [3:0] faultIcons,
  input wire logic safeState,
  input wire logic signed [7:0] coldRef
);
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  chk_unmapped_err:
    assert property (psel && !penable && !pwrite && paddr > 8'h28 |=> pslverr && prdata == 32'h0)
    else $error("Unmapped read not flagged");
  chk_rdata_stands:
    assert property (psel && penable |=> $stable(prdata) && $stable(pslverr))
    else $error("Read data moved after access");
  chk_break_relays:
    assert property (breakFault[0] [*3] |=> !outputRelayOne && !outputRelayTwo)
    else $error("Relay energized during cable break");
  chk_break_icon:
    assert property (breakFault[0] [*3] |=> indRed && faultIcons[1])
    else $error("Cable break not shown");
  chk_short_icon:
    assert property (shortFault[0] [*3] |=> indRed && faultIcons[0])
    else $error("Short circuit not shown");
  chk_range_icon:
    assert property (rangeFault[0] [*3] |=> indRed && faultIcons[2])
    else $error("Out of range not shown");
  chk_safe_relays:
    assert property (safeState [*2] |-> !outputRelayOne && !outputRelayTwo)
    else $error("Relay energized in safe state");
  chk_cold_range:
    assert property (coldRef >= -8'sd25 && coldRef <= 8'sd80)
    else $error("Cold junction value out of range");
endmodule
bind tlm_ctrl tlm_ctrl_chk i_chk (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .prdata,
  .pslverr, .shortFault, .breakFault, .rangeFault, .outputRelayOne, .outputRelayTwo,
  .indRed, .faultIcons, .safeState, .coldRef);
`default_nettype wire

//--- test/tlm_field_model.sv
// Sensors and remote rearm contact on the far side of the monitor
`timescale 1ns/1ps
`default_nettype none
module tlm_field_model #(
  parameter int TICK_CYC = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic signed [15:0] baseTemp,
  input wire logic go,
  input wire logic [31:0] holdMs,
  output logic signed [15:0] sensorInputOne,
  output logic signed [15:0] sensorInputTwo,
  output logic signed [15:0] sensorInputThree,
  output logic signed [15:0] loopMeas,
  output logic remoteRearmClosed
);
  logic [31:0] cnt;
  // Inputs 100 apart, so the learn source is visible in the limits
  assign sensorInputOne = baseTemp;
  assign sensorInputTwo = baseTemp + 16'sd100;
  assign sensorInputThree = baseTemp + 16'sd200;
  assign loopMeas = baseTemp;
  // ----------------------------------------
  // Contact closure of exact length
  // ----------------------------------------
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt <= 32'h0;
      remoteRearmClosed <= 1'b0;
    end
    else if (go)
    begin
      cnt <= holdMs * TICK_CYC;
      remoteRearmClosed <= 1'b1;
    end
    else if (cnt > 32'h1)
      cnt <= cnt - 32'h1;
    else
    begin
      cnt <= 32'h0;
      remoteRearmClosed <= 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- test/tb.sv
// Register-level testbench for the limit monitor control core
`timescale 1ns/1ps
`default_nettype none
`include "tlm_consts.vh"
module tb;
  // Short tick keeps closures cheap; stuck threshold stays above 2000 ms
  localparam int TICK = 4;
  localparam int STUCK = 2600;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, go;
  logic expLinkOk, paramErr, remoteRearmClosed, fieldbusResetCmd, enterButton, savedTrip;
  logic outputRelayOne, outputRelayTwo, indRed, safeState, setMode, tripToSave, coldExt;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdat, holdMs;
  logic signed [15:0] baseTemp, sensorInputOne, sensorInputTwo, sensorInputThree, loopMeas;
  logic [2:0] shortFault, breakFault;
  logic [3:0] rangeFault, faultIcons;
  logic signed [7:0] coldRef;
  int fails = 0;
  int n_tests = 0;
  tlm_ctrl #(.TICK_CYC(TICK), .STUCK_MS(STUCK)) i_dut (.clk, .rst_n, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .sensorInputOne, .sensorInputTwo,
    .sensorInputThree, .loopMeas, .shortFault, .breakFault, .rangeFault, .expLinkOk, .paramErr,
    .remoteRearmClosed, .fieldbusResetCmd, .enterButton, .savedTrip, .tripToSave,
    .outputRelayOne, .outputRelayTwo, .indRed, .faultIcons, .safeState, .setMode, .coldRef,
    .coldExt);
  tlm_field_model #(.TICK_CYC(TICK)) i_fld (.clk, .rst_n, .baseTemp, .go, .holdMs,
    .sensorInputOne, .sensorInputTwo, .sensorInputThree, .loopMeas, .remoteRearmClosed);
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Called just after an edge; request held until pready is seen high
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    int i;
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    cyc(1);
    penable <= 1'b1;
    for (i = 0; i < 16; i++)
    begin
      cyc(1);
      if (pready === 1'b1)
        break;
    end
    rdat = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle edge, so the next call never reassigns psel in this time step
    cyc(1);
    if (i == 16)
    begin
      chk("pready", 32'h1, 32'h0);
      end_of_test();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string n);
    bus(a, 1'b0, 32'h0);
    chk(n, e, rdat);
  endtask
  task automatic rly(input logic e);
    cyc(10);
    chk("relay1", {31'h0, e}, {31'h0, outputRelayOne});
    chk("relay2", {31'h0, e}, {31'h0, outputRelayTwo});
  endtask
  task automatic rearm(input int ms);
    go <= 1'b1;
    holdMs <= ms;
    cyc(1);
    go <= 1'b0;
    cyc(ms * TICK + 10);
  endtask
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial
  begin
    {rst_n, psel, penable, pwrite, go, paramErr, fieldbusResetCmd, enterButton} = 8'h0;
    {savedTrip, shortFault, breakFault, rangeFault} = 11'h0;
    {paddr, pwdata, holdMs} = 72'h0;
    expLinkOk = 1'b1;
    baseTemp = 16'sd100;
    cyc(8);
    rst_n <= 1'b1;
    cyc(1);
    rdc(`TLM_A_CFG, `TLM_CFG_RST, "cfg");
    rdc(`TLM_A_PIN, 32'h0, "pin");
    rdc(`TLM_A_OFFS, 32'h0, "offs");
    rdc(8'h2C, 32'h0, "unmapped");
    chk("slverr", 32'h1, {31'h0, pslverr});
    wr(`TLM_A_CFG, 32'h20F);
    rdc(`TLM_A_CFG, 32'h208, "loop only");
    wr(`TLM_A_CFG, 32'h207);
    rdc(`TLM_A_CFG, 32'h207, "three sensors");
    wr(`TLM_A_CFG, 32'h267);
    rdc(`TLM_A_CFG, 32'h268, "hazardous loop");
    wr(`TLM_A_CFG, 32'h5211);
    rdc(`TLM_A_CFG, 32'h211, "exp type refused");
    wr(`TLM_A_CFG, 32'h327);
    rdc(`TLM_A_CFG, 32'h227, "window refused");
    wr(`TLM_A_CFG, 32'h601);
    rdc(`TLM_A_CFG, 32'h201, "auto off");
    wr(`TLM_A_OFFS, 32'h7F9C6364);
    rdc(`TLM_A_OFFS, 32'h0A9D6363, "offs clamp");
    wr(`TLM_A_OFFS, 32'h0);
    wr(`TLM_A_COLD, 32'h80);
    rdc(`TLM_A_COLD, 32'hFFFFFFE7, "cold low");
    wr(`TLM_A_COLD, 32'h7F);
    rdc(`TLM_A_COLD, {24'h0, `TLM_COLD_MAX}, "cold high");
    wr(`TLM_A_CFG, 32'h15201);
    cyc(2);
    chk("cold ext", 32'h1, {31'h0, coldExt});
    wr(`TLM_A_CFG, 32'h206);
    wr(`TLM_A_CMD, 32'h4);
    rdc(`TLM_A_LIM2, 32'd210, "lim2 over");
    rdc(`TLM_A_LIM1, 32'd220, "lim1 over");
    wr(`TLM_A_CFG, 32'h284);
    wr(`TLM_A_CMD, 32'h4);
    rdc(`TLM_A_LIM2, 32'd285, "lim2 under");
    rdc(`TLM_A_LIM1, 32'd270, "lim1 under");
    wr(`TLM_A_CFG, 32'h001);
    wr(`TLM_A_LIM1, 32'd150);
    wr(`TLM_A_LIM2, 32'd120);
    wr(`TLM_A_HYST, 32'd5);
    baseTemp <= 16'sd200;
    rly(1'b0);
    rearm(500);
    rly(1'b0);
    baseTemp <= 16'sd100;
    rearm(100);
    rly(1'b0);
    rearm(2500);
    rly(1'b0);
    rearm(500);
    rly(1'b1);
    baseTemp <= 16'sd200;
    cyc(10);
    baseTemp <= 16'sd100;
    rly(1'b0);
    fieldbusResetCmd <= 1'b1;
    cyc(1);
    fieldbusResetCmd <= 1'b0;
    rly(1'b1);
    wr(`TLM_A_DLY, 32'h2);
    baseTemp <= 16'sd200;
    rly(1'b1);
    cyc(1300);
    rly(1'b0);
    baseTemp <= 16'sd100;
    wr(`TLM_A_DLY, 32'h0);
    wr(`TLM_A_CFG, 32'h411);
    baseTemp <= 16'sd200;
    rly(1'b0);
    baseTemp <= 16'sd100;
    rly(1'b1);
    for (int k = 0; k < 4; k++)
    begin
      shortFault <= {2'b0, k == 0};
      breakFault <= {2'b0, k == 1};
      rangeFault <= {3'b0, k == 2};
      expLinkOk <= k != 3;
      cyc(5);
      chk("icons", 32'h1 << k, {28'h0, faultIcons});
      chk("red", 32'h1, {31'h0, indRed});
    end
    expLinkOk <= 1'b1;
    wr(`TLM_A_PIN, 32'h10000);
    rdc(`TLM_A_CFG, 32'h411, "cfg kept");
    wr(`TLM_A_CFG, 32'h201);
    rdc(`TLM_A_CFG, 32'h411, "locked cfg");
    wr(`TLM_A_PIN, 32'h40000);
    wr(`TLM_A_CMD, 32'h3);
    cyc(3);
    chk("safe", 32'h1, {31'h0, safeState});
    rdc(`TLM_A_CFG, `TLM_CFG_RST, "factory cfg");
    rdc(`TLM_A_PIN, 32'h0, "factory pin");
    wr(`TLM_A_PIN, 32'h20000);
    wr(`TLM_A_PIN, 32'h20005);
    wr(`TLM_A_PIN, 32'h40005);
    rdc(`TLM_A_PIN, 32'h80000, "new code");
    enterButton <= 1'b1;
    cyc(2100 * TICK);
    enterButton <= 1'b0;
    cyc(2);
    chk("set mode", 32'h1, {31'h0, setMode});
    chk("safe left", 32'h0, {31'h0, safeState});
    wr(`TLM_A_CMD, 32'h20);
    rearm(STUCK + 100);
    rdc(`TLM_A_ERR, {16'h0, `TLM_ERR_STUCK}, "stuck");
    paramErr <= 1'b1;
    cyc(1);
    paramErr <= 1'b0;
    cyc(3);
    chk("param safe", 32'h1, {31'h0, safeState});
    rst_n <= 1'b0;
    savedTrip <= 1'b1;
    // Below both default limits, so only the saved state can trip relay one
    baseTemp <= -16'sd10;
    cyc(3);
    rst_n <= 1'b1;
    cyc(4);
    rdc(`TLM_A_ERR, 32'h0, "err cleared");
    chk("saved trip", 32'h0, {31'h0, outputRelayOne});
    chk("no saved trip2", 32'h1, {31'h0, outputRelayTwo});
    chk("trip to save", 32'h1, {31'h0, tripToSave});
    end_of_test();
  end
endmodule
`default_nettype wire
